// [scs_pkg.sv]
// Constants, offsets and types shared by the string-compare sequencer
package scs_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_INSTR1  = 8'h08;
	localparam logic [7:0] OFF_INSTR2  = 8'h0c;
	localparam logic [7:0] OFF_SRCPTR  = 8'h10;
	localparam logic [7:0] OFF_DSTPTR  = 8'h14;
	localparam logic [7:0] OFF_COUNT   = 8'h18;
	localparam logic [7:0] OFF_FLAGS   = 8'h1c;
	localparam logic [7:0] OFF_PCSTART = 8'h20;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_SEG   = 1;

	// Status register fields
	localparam int STAT_BUSY    = 0;
	localparam int STAT_DONE    = 1;
	localparam int STAT_SUSPEND = 2;
	localparam int STAT_ILLEGAL = 3;

	// Flag register fields
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_S = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_D = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_W = 6;

	// Reset values
	localparam logic [31:0] RST_PTR   = 32'h0000_0000;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [5:0]  RST_FLAGS = 6'h00;

	// Instruction encoding
	localparam logic [6:0] OPC_PREFIX  = 7'h5d;
	localparam logic [3:0] SEC_PREFIX  = 4'h0;
	localparam logic [3:0] NIB_DEC_REP = 4'he;
	localparam logic [3:0] NIB_INC_ONE = 4'h2;
	localparam logic [3:0] NIB_INC_REP = 4'h6;
	localparam logic [3:0] FIELD_ZERO  = 4'h0;

	// Cycle counts: setup, per element, per accepted interrupt
	localparam int SETUP_CYC = 11;
	localparam int STEP_CYC  = 14;
	localparam int INT_CYC   = 7;
	localparam logic [4:0] SETUP_LAST = 5'(SETUP_CYC - 1);
	localparam logic [4:0] STEP_LAST  = 5'(STEP_CYC - 1);
	localparam logic [4:0] INT_LAST   = 5'(INT_CYC - 1);

	// Condition codes
	localparam logic [3:0] CC_F   = 4'h0;
	localparam logic [3:0] CC_LT  = 4'h1;
	localparam logic [3:0] CC_LE  = 4'h2;
	localparam logic [3:0] CC_ULE = 4'h3;
	localparam logic [3:0] CC_OV  = 4'h4;
	localparam logic [3:0] CC_MI  = 4'h5;
	localparam logic [3:0] CC_EQ  = 4'h6;
	localparam logic [3:0] CC_ULT = 4'h7;
	localparam logic [3:0] CC_T   = 4'h8;
	localparam logic [3:0] CC_GE  = 4'h9;
	localparam logic [3:0] CC_GT  = 4'ha;
	localparam logic [3:0] CC_UGT = 4'hb;
	localparam logic [3:0] CC_NOV = 4'hc;
	localparam logic [3:0] CC_PL  = 4'hd;
	localparam logic [3:0] CC_NE  = 4'he;
	localparam logic [3:0] CC_UGE = 4'hf;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_RDSRC = 3'b010,
		ST_RDDST = 3'b011,
		ST_PAD   = 3'b100,
		ST_INTR  = 3'b101
	} scs_fsm_t;

endpackage

// [scs_cmp_alu.sv]
// Compare subtractor and condition evaluation for one string element
`timescale 1ns/1ns
module scs_cmp_alu
	import scs_pkg::*;
(
	// Operands
	input  wire logic [15:0] dstVal,
	input  wire logic [15:0] srcVal,
	input  wire logic        wordSel,
	input  wire logic [3:0]  condSel,
	// Results
	output logic             condMet,
	output logic             borrow,
	output logic             negative
);

	logic [16:0] diffW;   // Word difference with carry bit
	logic [8:0]  diffB;   // Byte difference with carry bit
	logic        zero;    // Result is zero
	logic        ovf;     // Signed overflow of the subtraction

	// Subtract source from destination at the chosen width
	always_comb begin
		diffW = {1'b0, dstVal} - {1'b0, srcVal};
		diffB = {1'b0, dstVal[7:0]} - {1'b0, srcVal[7:0]};
		if (wordSel) begin
			borrow   = diffW[16];
			negative = diffW[15];
			zero     = (diffW[15:0] == 16'h0000);
			ovf      = (dstVal[15] != srcVal[15]) &&
				(diffW[15] != dstVal[15]);
		end else begin
			borrow   = diffB[8];
			negative = diffB[7];
			zero     = (diffB[7:0] == 8'h00);
			ovf      = (dstVal[7] != srcVal[7]) &&
				(diffB[7] != dstVal[7]);
		end
	end

	// Evaluate the selected condition on the subtraction
	always_comb begin
		unique case (condSel)
			CC_F:    condMet = 1'b0;
			CC_LT:   condMet = negative ^ ovf;
			CC_LE:   condMet = zero | (negative ^ ovf);
			CC_ULE:  condMet = borrow | zero;
			CC_OV:   condMet = ovf;
			CC_MI:   condMet = negative;
			CC_EQ:   condMet = zero;
			CC_ULT:  condMet = borrow;
			CC_T:    condMet = 1'b1;
			CC_GE:   condMet = ~(negative ^ ovf);
			CC_GT:   condMet = ~(zero | (negative ^ ovf));
			CC_UGT:  condMet = ~(borrow | zero);
			CC_NOV:  condMet = ~ovf;
			CC_PL:   condMet = ~negative;
			CC_NE:   condMet = ~zero;
			CC_UGE:  condMet = ~borrow;
		endcase
	end

endmodule

// [scs_string_compare.sv]
// String-compare sequencer with AHB-Lite register slave and memory port
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module scs_string_compare
	import scs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Memory read port
	output logic             memReq,
	output logic      [31:0] memAddr,
	output logic             memWordSel,
	input  wire logic [15:0] memRdata,
	input  wire logic        memAck,
	// Interrupt hand-off
	input  wire logic        intReq,
	output logic             intAck,
	output logic      [15:0] savedPc,
	// Activity
	output logic             busy
);

	// Complete block state
	typedef struct packed {
		scs_fsm_t    state;     // Sequencer state
		logic [4:0]  tmr;       // Setup and interrupt timer
		logic [4:0]  stepCnt;   // Cycles spent in the current step
		logic [15:0] instr1;    // First instruction word
		logic [15:0] instr2;    // Second instruction word
		logic [31:0] srcPtr;    // Source pointer
		logic [31:0] dstPtr;    // Destination pointer
		logic [15:0] count;     // Element counter
		logic [5:0]  flags;     // C Z S V D H
		logic [15:0] pcStart;   // Address of the instruction start
		logic        segMode;   // Segmented addressing
		logic        stDone;    // Instruction finished
		logic        stSusp;    // Instruction suspended by interrupt
		logic        stIllegal; // Start refused on bad encoding
		logic [15:0] srcVal;    // Fetched source element
		logic [15:0] dstVal;    // Fetched destination element
		logic        memReq;    // Memory request level
		logic [31:0] memAddr;   // Memory address
		logic        intAck;    // Interrupt accepted pulse
		logic [15:0] savedPc;   // Restart address handed over
		logic        wrPend;    // Write data phase pending
		logic [7:0]  wrAddr;    // Address of pending write
		logic [31:0] hrdata;    // Read data for the data phase
	} scs_state_t;

	scs_state_t q;              // Registered state
	scs_state_t d;              // Next state

	logic        wordSel;       // Element width from size bit
	logic        isDec;         // Pointers move downward
	logic        isRep;         // Repeating form
	logic        legal;         // Instruction words decode
	logic        condMet;       // Selected condition holds
	logic        borrow;        // Borrow out of the compare
	logic        negative;      // Compare result sign
	logic [15:0] cntDec;        // Counter after decrement
	logic        cntZero;       // Decremented counter is zero
	logic        stopNow;       // Repeat ends after this step
	logic        startReq;      // Start bit written this cycle
	logic        addrPhase;     // Valid AHB address phase
	logic [31:0] rdVal;         // Read mux output

	// Pointer step by element size, segment word kept only in segmented mode
	function automatic logic [31:0] movePtr(input logic [31:0] p,
			input logic down, input logic word, input logic seg);
		logic [15:0] amt;
		logic [15:0] off;
		amt = word ? 16'h0002 : 16'h0001;
		off = down ? p[15:0] - amt : p[15:0] + amt;
		return {seg ? p[31:16] : 16'h0000, off};
	endfunction

	// Memory address from a pointer register or register pair
	function automatic logic [31:0] ptrAddr(input logic [31:0] p,
			input logic seg);
		return {seg ? p[31:16] : 16'h0000, p[15:0]};
	endfunction

	// Instruction decode from the held words
	assign wordSel = q.instr1[8];
	assign isDec   = (q.instr1[3:0] == NIB_DEC_REP);
	assign isRep   = (q.instr1[3:0] == NIB_DEC_REP) ||
		(q.instr1[3:0] == NIB_INC_REP);
	// Fields must be nonzero; nibble picks the form
	assign legal   = (q.instr1[15:9] == OPC_PREFIX) &&
		(q.instr1[7:4] != FIELD_ZERO) &&
		(q.instr2[15:12] == SEC_PREFIX) &&
		(q.instr2[7:4] != FIELD_ZERO) &&
		((q.instr1[3:0] == NIB_DEC_REP) ||
		(q.instr1[3:0] == NIB_INC_ONE) ||
		(q.instr1[3:0] == NIB_INC_REP));

	// Counter bookkeeping for the current step
	assign cntDec  = q.count - 16'h0001;
	assign cntZero = (cntDec == 16'h0000);
	assign stopNow = condMet || cntZero || !isRep;

	// AHB address phase qualifier
	assign addrPhase = hsel && htrans[1] && hready;

	// Compare datapath
	scs_cmp_alu scs_cmp_alu_inst (
		.dstVal   (q.dstVal),
		.srcVal   (q.srcVal),
		.wordSel  (wordSel),
		.condSel  (q.instr2[3:0]),
		.condMet  (condMet),
		.borrow   (borrow),
		.negative (negative)
	);

	// Register read multiplexer
	always_comb begin
		rdVal = 32'h0000_0000;
		case (haddr[7:0])
			OFF_CTRL:    rdVal[CTRL_SEG] = q.segMode;
			OFF_STATUS: begin
				rdVal[STAT_BUSY]    = (q.state != ST_IDLE);
				rdVal[STAT_DONE]    = q.stDone;
				rdVal[STAT_SUSPEND] = q.stSusp;
				rdVal[STAT_ILLEGAL] = q.stIllegal;
			end
			OFF_INSTR1:  rdVal[15:0] = q.instr1;
			OFF_INSTR2:  rdVal[15:0] = q.instr2;
			OFF_SRCPTR:  rdVal = ptrAddr(q.srcPtr, q.segMode);
			OFF_DSTPTR:  rdVal = ptrAddr(q.dstPtr, q.segMode);
			OFF_COUNT:   rdVal[15:0] = q.count;
			OFF_FLAGS:   rdVal[FLAG_W-1:0] = q.flags;
			OFF_PCSTART: rdVal[15:0] = q.pcStart;
			default:     rdVal = 32'h0000_0000;  // Unmapped reads zero
		endcase
	end

	// Next-state logic: bus slave first, then the sequencer
	always_comb begin
		d        = q;
		d.intAck = 1'b0;
		d.wrPend = 1'b0;
		startReq = 1'b0;
		// Data phase of a write; engine registers locked while busy
		if (q.wrPend && (q.state == ST_IDLE)) begin
			case (q.wrAddr)
				OFF_CTRL: begin
					d.segMode = hwdata[CTRL_SEG];
					startReq  = hwdata[CTRL_START];
				end
				OFF_INSTR1:  d.instr1  = hwdata[15:0];
				OFF_INSTR2:  d.instr2  = hwdata[15:0];
				OFF_SRCPTR:  d.srcPtr  = hwdata;
				OFF_DSTPTR:  d.dstPtr  = hwdata;
				OFF_COUNT:   d.count   = hwdata[15:0];
				OFF_FLAGS:   d.flags   = hwdata[FLAG_W-1:0];
				OFF_PCSTART: d.pcStart = hwdata[15:0];
				default:     d.wrPend  = 1'b0;  // Ignored, still OKAY
			endcase
		end
		// Address phase: latch writes, register read data
		if (addrPhase) begin
			if (hwrite) begin
				d.wrPend = 1'b1;
				d.wrAddr = haddr[7:0];
			end else begin
				d.hrdata = rdVal;
			end
		end
		// Sequencer
		unique case (q.state)
			ST_IDLE: begin
				// Start: check encoding, then begin setup
				if (startReq) begin
					d.stDone    = 1'b0;
					d.stSusp    = 1'b0;
					d.stIllegal = !legal;
					if (legal) begin
						d.state = ST_SETUP;
						d.tmr   = SETUP_LAST;
					end
				end
			end
			ST_SETUP: begin
				// Fixed setup overhead, then first source read
				if (q.tmr == 5'h00) begin
					d.state   = ST_RDSRC;
					d.stepCnt = 5'h00;
					d.memReq  = 1'b1;
					d.memAddr = ptrAddr(q.srcPtr, q.segMode);
				end else begin
					d.tmr = q.tmr - 5'h01;
				end
			end
			ST_RDSRC: begin
				// Source element, then destination address
				d.stepCnt = q.stepCnt + 5'h01;
				if (memAck) begin
					d.srcVal  = memRdata;
					d.state   = ST_RDDST;
					d.memAddr = ptrAddr(q.dstPtr, q.segMode);
				end
			end
			ST_RDDST: begin
				// Destination element closes the memory reads
				d.stepCnt = q.stepCnt + 5'h01;
				if (memAck) begin
					d.dstVal = memRdata;
					d.memReq = 1'b0;
					d.state  = ST_PAD;
				end
			end
			ST_PAD: begin
				// Fill the step to its fixed length, then commit
				d.stepCnt = q.stepCnt + 5'h01;
				if (q.stepCnt >= STEP_LAST) begin
					// C and S from the compare, Z from the condition, V from the counter end; D and H held
					d.flags[FLAG_Z] = condMet;
					d.flags[FLAG_C] = borrow;
					d.flags[FLAG_S] = negative;
					d.flags[FLAG_V] = cntZero;
					d.count  = cntDec;
					// Both pointers move by the element size
					d.srcPtr = movePtr(q.srcPtr, isDec, wordSel,
						q.segMode);
					d.dstPtr = movePtr(q.dstPtr, isDec, wordSel,
						q.segMode);
					if (stopNow) begin
						d.state  = ST_IDLE;
						d.stDone = 1'b1;
					end else if (intReq) begin
						d.state = ST_INTR;
						d.tmr   = INT_LAST;
					end else begin
						d.state   = ST_RDSRC;
						d.stepCnt = 5'h00;
						d.memReq  = 1'b1;
						d.memAddr = ptrAddr(d.srcPtr, q.segMode);
					end
				end
			end
			ST_INTR: begin
				// Interrupt overhead, hand back the start address
				if (q.tmr == 5'h00) begin
					d.state   = ST_IDLE;
					d.stSusp  = 1'b1;
					d.intAck  = 1'b1;
					d.savedPc = q.pcStart;
				end else begin
					d.tmr = q.tmr - 5'h01;
				end
			end
			default: d.state = ST_IDLE;  // Recover from illegal code
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q.state     <= ST_IDLE;
			q.tmr       <= 5'h00;
			q.stepCnt   <= 5'h00;
			q.instr1    <= RST_WORD;
			q.instr2    <= RST_WORD;
			q.srcPtr    <= RST_PTR;
			q.dstPtr    <= RST_PTR;
			q.count     <= RST_WORD;
			q.flags     <= RST_FLAGS;
			q.pcStart   <= RST_WORD;
			q.segMode   <= 1'b0;
			q.stDone    <= 1'b0;
			q.stSusp    <= 1'b0;
			q.stIllegal <= 1'b0;
			q.srcVal    <= RST_WORD;
			q.dstVal    <= RST_WORD;
			q.memReq    <= 1'b0;
			q.memAddr   <= RST_PTR;
			q.intAck    <= 1'b0;
			q.savedPc   <= RST_WORD;
			q.wrPend    <= 1'b0;
			q.wrAddr    <= 8'h00;
			q.hrdata    <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign hrdata     = q.hrdata;
	assign hreadyout  = 1'b1;     // Zero wait states
	assign hresp      = 1'b0;     // Always OKAY
	assign memReq     = q.memReq;
	assign memAddr    = q.memAddr;
	assign memWordSel = wordSel;
	assign intAck     = q.intAck;
	assign savedPc    = q.savedPc;
	assign busy       = (q.state != ST_IDLE);

endmodule

// [scs_string_compare_monitor.sv]
// Port-level checks for the string-compare sequencer
`timescale 1ns/1ns
module scs_string_compare_monitor
	import scs_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Memory read port
	input wire logic        memReq,
	input wire logic [31:0] memAddr,
	input wire logic        memWordSel,
	input wire logic        memAck,
	// Interrupt hand-off and activity
	input wire logic        intAck,
	input wire logic [15:0] savedPc,
	input wire logic        busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [15:0] lenQ;  // Length of latest busy run, held after it
	logic        busyQ; // Busy one cycle ago
	// Count busy cycles, restart on each rise
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lenQ  <= 16'h0000;
			busyQ <= 1'b0;
		end else begin
			busyQ <= busy;
			if (busy) begin
				lenQ <= busyQ ? lenQ + 16'h0001 : 16'h0001;
			end
		end
	end
	a_req_held: assert property (
		memReq && !memAck |=> memReq && $stable(memAddr))
		else $error("read request moved before its ack");
	a_req_busy: assert property (
		memReq |-> busy)
		else $error("read request while idle");
	a_drop_on_ack: assert property (
		$fell(memReq) |-> $past(memAck))
		else $error("read request dropped without ack");
	a_setup_gap: assert property (
		$rose(busy) |-> (!memReq)[*8] ##1 (!memReq)[*3] ##1 memReq)
		else $error("first read not right after setup");
	a_busy_len: assert property (
		$fell(busy) |-> lenQ >= 16'd25 && (lenQ % STEP_CYC == SETUP_CYC
		|| lenQ % STEP_CYC == SETUP_CYC + INT_CYC - STEP_CYC))
		else $error("run length not setup plus whole steps");
	a_int_len: assert property (
		intAck |-> !busy && lenQ % STEP_CYC == 4)
		else $error("hand-off without seven extra cycles");
	a_ack_pulse: assert property (
		intAck |=> !intAck)
		else $error("hand-off longer than one cycle");
	a_pc_on_ack: assert property (
		$changed(savedPc) |-> intAck)
		else $error("saved start moved without hand-off");
	a_size_steady: assert property (
		busy && $past(busy) |-> $stable(memWordSel))
		else $error("element size changed mid-run");
	c_hand_off: cover property (intAck);
	c_long_run: cover property ($fell(busy) && lenQ > 16'd25);
	c_slow_read: cover property (memReq && !memAck);
endmodule

// [scs_mem_model.sv]
// Behavioural system memory on the sequencer's read port
`timescale 1ns/1ns
module scs_mem_model
	import scs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Read port
	input  wire logic        memReq,
	input  wire logic [31:0] memAddr,
	input  wire logic        memWordSel,
	output logic      [15:0] memRdata,
	output logic             memAck,
	// Wait cycles before each ack
	input  wire logic [3:0]  stall
);
	logic [7:0]  memB [0:255]; // Filled by the bench, never written
	logic [3:0]  waitQ;        // Cycles the current read has waited
	logic [7:0]  idx;          // Low address byte picks the location
	logic [15:0] rdWord;       // Element at the address
	// Count waits on the pending read
	always_ff @(posedge sys_clk) begin
		if (rst || !memReq || memAck) begin
			waitQ <= 4'h0;
		end else begin
			waitQ <= waitQ + 4'h1;
		end
	end
	// Ack once the wait has run out
	assign memAck = memReq && (waitQ >= stall);
	// Word is two bytes; a byte sits low with junk above it
	assign idx = memAddr[7:0];
	assign rdWord = memWordSel ? {memB[idx], memB[idx + 8'h01]}
		: {~memB[idx], memB[idx]};
	// Inverted data outside the ack cycle
	assign memRdata = memAck ? rdWord : ~rdWord;
endmodule

// [test_string_compare_sequencer.sv]
// Self-checking bench for the string-compare sequencer
`timescale 1ns/1ns
module test_string_compare_sequencer
	import scs_pkg::*;
;
	logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, memAddr, gS, gD;
	logic        memReq, memWordSel, memAck, intReq, intAck, busy;
	logic [15:0] memRdata, savedPc, gN, bi1, bi2;
	logic [3:0]  stall;
	int          n_errors;
	int          comparisons;
	assign hready = hreadyout;
	// Device under test
	scs_string_compare scs_string_compare_inst (
		.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .memReq(memReq), .memAddr(memAddr),
		.memWordSel(memWordSel), .memRdata(memRdata), .memAck(memAck),
		.intReq(intReq), .intAck(intAck), .savedPc(savedPc), .busy(busy));
	// Memory on the far side
	scs_mem_model scs_mem_model_inst (
		.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memAddr(memAddr),
		.memWordSel(memWordSel), .memRdata(memRdata), .memAck(memAck),
		.stall(stall));
	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict and stop
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Wait for hready at an edge, bounded
	task automatic rdy_wait();
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (hready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// One AHB-Lite single transfer
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		rdy_wait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy_wait();
		q = hrdata;
	endtask
	// Register write
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	// Register read and compare
	task automatic creg(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		check(nm, q, exp);
		check("response", {31'h0, hresp}, 32'h0);
	endtask
	// Condition on dst minus src flags
	function automatic logic cond(input logic [3:0] cc,
		input logic c, z, s, v);
		logic t;
		case (cc[2:0])
			3'h0: t = 1'b0;
			3'h1: t = s ^ v;
			3'h2: t = z | (s ^ v);
			3'h3: t = c | z;
			3'h4: t = v;
			3'h5: t = s;
			3'h6: t = z;
			default: t = c;
		endcase
		return t ^ cc[3];
	endfunction
	// Element from memory; a byte is moved to the top lane
	function automatic logic [15:0] elem(input logic [31:0] a, input logic w);
		logic [7:0] i;
		i = a[7:0];
		if (w) begin
			return {scs_mem_model_inst.memB[i], scs_mem_model_inst.memB[i + 8'h01]};
		end
		return {scs_mem_model_inst.memB[i], 8'h00};
	endfunction
	// Predict a run from gS/gD/gN, execute it, compare all results
	task automatic run(input logic [15:0] i1, i2, input logic seg, intr, rsm);
		logic        w, dec, rep, fin, c, sg, v, zf;
		logic [15:0] a, b, r, st, n0;
		logic [31:0] s0, d0;
		int          steps, cyc, k, ack;
		w = i1[8];
		dec = i1[3:0] == NIB_DEC_REP;
		rep = i1[3:0] != NIB_INC_ONE;
		st = w ? 16'h0002 : 16'h0001;
		s0 = gS;
		d0 = gD;
		n0 = gN;
		steps = 0;
		do begin
			a = elem(gD, w);
			b = elem(gS, w);
			r = a - b;
			c = a < b;
			sg = r[15];
			v = (a[15] ^ b[15]) & (r[15] ^ a[15]);
			zf = cond(i2[3:0], c, r == 16'h0, sg, v);
			gN = gN - 16'h1;
			gS[15:0] = dec ? gS[15:0] - st : gS[15:0] + st;
			gD[15:0] = dec ? gD[15:0] - st : gD[15:0] + st;
			steps++;
			fin = !rep || zf || gN == 16'h0;
		end while (!fin && !intr);
		if (!rsm) begin
			wreg(OFF_FLAGS, 32'h30);
			wreg(OFF_INSTR1, {16'h0, i1});
			wreg(OFF_INSTR2, {16'h0, i2});
			wreg(OFF_SRCPTR, s0);
			wreg(OFF_DSTPTR, d0);
			wreg(OFF_COUNT, {16'h0, n0});
			wreg(OFF_PCSTART, 32'h0abc);
		end
		intReq <= intr;
		wreg(OFF_CTRL, {30'h0, seg, 1'b1});
		cyc = 0;
		k = 0;
		ack = 0;
		do begin
			@(posedge sys_clk);
			k++;
			ack += int'(intAck === 1'b1);
			cyc += int'(busy === 1'b1);
		end while ((busy === 1'b1 || cyc == 0) && k < 3000);
		repeat (2) begin
			@(posedge sys_clk);
			ack += int'(intAck === 1'b1);
		end
		if (k >= 3000) begin
			n_errors++;
			end_of_test();
		end
		intReq <= 1'b0;
		check("cycles", 32'(cyc),
			32'(SETUP_CYC + STEP_CYC * steps + (fin ? 0 : INT_CYC)));
		check("hand-off", 32'(ack), {31'h0, !fin});
		creg("source", OFF_SRCPTR, gS);
		creg("destination", OFF_DSTPTR, gD);
		creg("count", OFF_COUNT, {16'h0, gN});
		creg("flags", OFF_FLAGS, {26'h0, 2'b11, gN == 16'h0, sg, zf, c});
		creg("status", OFF_STATUS, fin ? 32'h2 : 32'h4);
		if (!fin) begin
			check("saved start", {16'h0, savedPc}, 32'h0abc);
		end
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata, intReq} = '0;
		hsize = 3'b010;
		stall = 4'h0;
		for (int i = 0; i < 256; i++) begin
			scs_mem_model_inst.memB[i] = 8'(i * 37 + 11);
		end
		for (int i = 0; i < 4; i++) begin
			scs_mem_model_inst.memB[16 + 2 * i] = 8'h00;
			scs_mem_model_inst.memB[17 + 2 * i] = 8'(2 * i);
			scs_mem_model_inst.memB[32 + 2 * i] = 8'h00;
			scs_mem_model_inst.memB[33 + 2 * i] = 8'(i == 1 || i == 2);
			scs_mem_model_inst.memB[48 + i] = 8'(2 * i);
			scs_mem_model_inst.memB[56 + i] = 8'(i == 1 || i == 2);
		end
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		creg("count", OFF_COUNT, 32'h0);
		creg("flags", OFF_FLAGS, 32'h0);
		creg("unmapped", 8'h40, 32'h0);
		$display("TEST reset values done");
		// Decrementing repeat, word then byte, equal found on last step
		for (int w = 1; w >= 0; w--) begin
			gS = w ? 32'h16 : 32'h33;
			gD = w ? 32'h26 : 32'h3b;
			gN = 16'h4;
			run({OPC_PREFIX, 1'(w), 4'h1, NIB_DEC_REP}, {SEC_PREFIX, 4'h2, 4'h3, CC_EQ}, 1'b0, 1'b0, 1'b0);
		end
		$display("TEST decrementing repeat done");
		// Single step through every condition, odd codes word and even codes byte
		for (int cc = 0; cc < 16; cc++) begin
			gS = 32'h80 + 32'(cc * 2);
			gD = 32'h40 + 32'(cc * 2);
			gN = cc[1] ? 16'h1 : 16'h5;
			run({OPC_PREFIX, cc[0], 4'h5, NIB_INC_ONE}, {SEC_PREFIX, 4'h2, 4'h6, 4'(cc)}, 1'b0, 1'b0, 1'b0);
		end
		$display("TEST single step done");
		// Segmented repeat, offset wrap, slow memory, suspend and resume
		stall <= 4'h2;
		for (int w = 0; w < 2; w++) begin
			gS = 32'h0003_fffd - 32'(w);
			gD = 32'h0005_00c0;
			gN = 16'h3;
			bi1 = {OPC_PREFIX, 1'(w), 4'h7, NIB_INC_REP};
			run(bi1, {SEC_PREFIX, 4'h2, 4'h6, CC_F}, 1'b1, 1'b1, 1'b0);
			run(bi1, {SEC_PREFIX, 4'h2, 4'h6, CC_F}, 1'b1, 1'b0, 1'b1);
		end
		stall <= 4'h0;
		$display("TEST segmented repeat done");
		// Bad encodings are refused
		for (int i = 0; i < 5; i++) begin
			bi1 = {i == 4 ? ~OPC_PREFIX : OPC_PREFIX, 1'b0,
				i == 1 ? 4'h0 : 4'h1, i == 0 ? 4'h4 : NIB_DEC_REP};
			bi2 = {i == 3 ? 4'h1 : SEC_PREFIX, 4'h2,
				i == 2 ? 4'h0 : 4'h3, CC_EQ};
			wreg(OFF_INSTR1, {16'h0, bi1});
			wreg(OFF_INSTR2, {16'h0, bi2});
			wreg(OFF_CTRL, 32'h1);
			repeat (3) @(posedge sys_clk);
			check("busy", {31'h0, busy}, 32'h0);
			creg("status", OFF_STATUS, 32'h8);
		end
		$display("TEST bad encodings done");
		end_of_test();
	end
endmodule
bind scs_string_compare scs_string_compare_monitor scs_string_compare_monitor_inst (
	.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memAddr(memAddr),
	.memWordSel(memWordSel), .memAck(memAck), .intAck(intAck),
	.savedPc(savedPc), .busy(busy));
